// *** design/pcp_consts.vh ***
// Constants shared by the code-convert and nibble-pack execution unit.
`ifndef PCP_CONSTS_VH
`define PCP_CONSTS_VH

// Operation codes presented on the command port.
`define PCP_OP_W                3
`define PCP_OP_BCD_TO_BINARY    3'h0
`define PCP_OP_BIT_DECODE       3'h1
`define PCP_OP_PRIORITY_ENCODE  3'h2
`define PCP_OP_NIBBLE_PACK      3'h3
`define PCP_OP_NIBBLE_NIBBLE_DISTRIBUTE_OP      3'h4

// Word, nibble and digit layout.
`define PCP_WORD_W              16
`define PCP_NIBBLE_W            4
`define PCP_NIBBLES             4
`define PCP_BCD_DIGIT_MAX       4'h9
`define PCP_MAX_WORDS           4'h4

// Width of the shift count n and of internal range counts.
`define PCP_N_W                 4
`define PCP_CNT_W               17

// Reset values of the two flags.
`define PCP_DER_RESET           1'b0
`define PCP_CARRY_RESET         1'b0

`endif

// *** design/pcp_bcd_to_bin.v ***
// Packed-decimal word to binary converter with per-digit range check.
`timescale 1ns/1ns
`include "pcp_consts.vh"

module pcp_bcd_to_bin (
   // Packed-decimal input word.
   input  wire [15:0] bcd_in,
   // Binary value and digit error.
   output wire [15:0] bin_out,
   output wire        digit_err
);

   wire [3:0]  dig_err;
   wire [63:0] term;

   // Each digit is weighted by its power of ten and checked for A to F.
   genvar i;
   generate
      for (i = 0; i < `PCP_NIBBLES; i = i + 1) begin : g_digit
         localparam [15:0] WEIGHT = (i == 0) ? 16'h0001 :
                                    (i == 1) ? 16'h000A :
                                    (i == 2) ? 16'h0064 : 16'h03E8;
         wire [3:0] dig = bcd_in[4*i+3:4*i];
         assign dig_err[i]           = (dig > `PCP_BCD_DIGIT_MAX);
         assign term[16*i+15:16*i]   = {12'h000, dig} * WEIGHT;
      end
   endgenerate

   // The sum of four legal digits never exceeds 9999, so 16 bits suffice.
   assign bin_out   = term[15:0] + term[31:16] + term[47:32] + term[63:48];
   assign digit_err = |dig_err;

endmodule

// *** design/pcp_unit.v ***
// Execution unit for code conversion, decode, encode, nibble pack and distribute.
`timescale 1ns/1ns
`include "pcp_consts.vh"

module pcp_unit (
   // Clock and reset.
   input  wire        clock,
   input  wire        rst,
   // Command port.
   input  wire        cmd_valid,
   output wire        cmd_ready,
   input  wire [2:0]  cmd_op,
   input  wire [15:0] cmd_dst,
   input  wire [15:0] cmd_src,
   input  wire [3:0]  cmd_n,
   input  wire [15:0] src_last,
   input  wire [15:0] dst_last,
   output reg         done_r,
   // Word port of the data memory.
   output reg  [15:0] wm_addr_r,
   output reg         wm_rd_r,
   input  wire [15:0] wm_rdata,
   output reg         wm_wr_r,
   output reg  [15:0] wm_wdata_r,
   // Bit port of the data memory.
   output reg  [15:0] bm_addr_r,
   output reg         bm_rd_r,
   input  wire        bm_rdata,
   output reg         bm_set_r,
   // Special internal flag outputs.
   output reg         data_error_flag_r,
   output reg         carry_flag_r
);

   // Sequencer states.
   localparam [1:0] S_IDLE = 2'h0;
   localparam [1:0] S_WAIT = 2'h1;
   localparam [1:0] S_CAP  = 2'h2;
   localparam [1:0] S_WR   = 2'h3;

   reg  [1:0]  state_r;
   reg  [2:0]  op_r;
   reg  [15:0] dst_r;
   reg  [15:0] src_r;
   reg  [3:0]  n_r;
   reg  [16:0] cnt_r;
   reg  [16:0] idx_r;
   reg         over_r;
   reg  [15:0] word_r;
   reg  [15:0] pos_r;
   reg         found_r;

   reg  [16:0] span_nxt;
   reg  [16:0] avail_nxt;
   reg  [16:0] cnt_nxt;
   reg         over_nxt;
   reg  [3:0]  nwords;
   reg  [15:0] chk_base;
   reg  [15:0] chk_last;

   wire [15:0] bin_val;
   wire        bcd_err;
   wire [16:0] idx_inc;
   wire        idx_last;
   wire [15:0] dec_mask;
   wire [15:0] dec_index;

   // Digit conversion is combinational on the returned memory word.
   pcp_bcd_to_bin u_bcd (
      .bcd_in    (wm_rdata),
      .bin_out   (bin_val),
      .digit_err (bcd_err)
   );

   assign cmd_ready = (state_r == S_IDLE);
   assign idx_inc   = idx_r + 17'h00001;
   assign idx_last  = (idx_inc == cnt_r);
   assign dec_mask  = ~(16'hFFFF << n_r);
   assign dec_index = wm_rdata & dec_mask;

   // Range of the operand that the area-end check applies to, taken at command time.
   // The span is worked out in 17 bits so that an area ending at the top of the
   // address space cannot wrap the comparison.
   always @* begin
      nwords = (cmd_n > `PCP_MAX_WORDS) ? `PCP_MAX_WORDS : cmd_n;
      if (cmd_op == `PCP_OP_BIT_DECODE || cmd_op == `PCP_OP_PRIORITY_ENCODE) begin
         span_nxt = 17'h00001 << cmd_n;
      end else begin
         span_nxt = {13'h0000, nwords};
      end
      if (cmd_op == `PCP_OP_PRIORITY_ENCODE || cmd_op == `PCP_OP_NIBBLE_PACK) begin
         chk_base = cmd_src;
         chk_last = src_last;
      end else begin
         chk_base = cmd_dst;
         chk_last = dst_last;
      end
      if (chk_base > chk_last) begin
         avail_nxt = 17'h00000;
      end else begin
         avail_nxt = {1'b0, chk_last} - {1'b0, chk_base} + 17'h00001;
      end
      over_nxt = (span_nxt > avail_nxt);
      cnt_nxt  = over_nxt ? avail_nxt : span_nxt;
   end

   // Main sequencer. Every memory strobe is registered and lasts one cycle, except that distribute's writes run back to back; a read
   // returns its data in the cycle after the strobe is seen.
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         state_r           <= S_IDLE;
         op_r              <= `PCP_OP_BCD_TO_BINARY;
         dst_r             <= 16'h0000;
         src_r             <= 16'h0000;
         n_r               <= 4'h0;
         cnt_r             <= 17'h00000;
         idx_r             <= 17'h00000;
         over_r            <= 1'b0;
         word_r            <= 16'h0000;
         pos_r             <= 16'h0000;
         found_r           <= 1'b0;
         done_r            <= 1'b0;
         wm_addr_r         <= 16'h0000;
         wm_rd_r           <= 1'b0;
         wm_wr_r           <= 1'b0;
         wm_wdata_r        <= 16'h0000;
         bm_addr_r         <= 16'h0000;
         bm_rd_r           <= 1'b0;
         bm_set_r          <= 1'b0;
         data_error_flag_r <= `PCP_DER_RESET;
         carry_flag_r      <= `PCP_CARRY_RESET;
      end else begin
         done_r   <= 1'b0;
         wm_rd_r  <= 1'b0;
         wm_wr_r  <= 1'b0;
         bm_rd_r  <= 1'b0;
         bm_set_r <= 1'b0;
         case (state_r)
            // Accept a command and issue the first read; an empty clipped range finishes at
            // once for distribute and writes a zero result for encode and pack.
            S_IDLE: begin
               if (cmd_valid) begin
                  op_r    <= cmd_op;
                  dst_r   <= cmd_dst;
                  src_r   <= cmd_src;
                  n_r     <= cmd_n;
                  cnt_r   <= cnt_nxt;
                  over_r  <= over_nxt;
                  idx_r   <= 17'h00000;
                  pos_r   <= 16'h0000;
                  found_r <= 1'b0;
                  word_r  <= 16'h0000;
                  case (cmd_op)
                     `PCP_OP_BCD_TO_BINARY, `PCP_OP_BIT_DECODE: begin
                        wm_addr_r <= cmd_src;
                        wm_rd_r   <= 1'b1;
                        state_r   <= S_WAIT;
                     end
                     `PCP_OP_PRIORITY_ENCODE: begin
                        if (cnt_nxt == 17'h00000) begin
                           // Nothing of the range lies in the area: result zero.
                           wm_addr_r         <= cmd_dst;
                           wm_wdata_r        <= 16'h0000;
                           wm_wr_r           <= 1'b1;
                           carry_flag_r      <= 1'b1;
                           data_error_flag_r <= over_nxt;
                           state_r           <= S_WR;
                        end else begin
                           bm_addr_r <= cmd_src;
                           bm_rd_r   <= 1'b1;
                           state_r   <= S_WAIT;
                        end
                     end
                     `PCP_OP_NIBBLE_PACK: begin
                        if (cnt_nxt == 17'h00000) begin
                           wm_addr_r         <= cmd_dst;
                           wm_wdata_r        <= 16'h0000;
                           wm_wr_r           <= 1'b1;
                           data_error_flag_r <= over_nxt;
                           state_r           <= S_WR;
                        end else begin
                           wm_addr_r <= cmd_src;
                           wm_rd_r   <= 1'b1;
                           state_r   <= S_WAIT;
                        end
                     end
                     `PCP_OP_NIBBLE_NIBBLE_DISTRIBUTE_OP: begin
                        if (cnt_nxt == 17'h00000) begin
                           // A zero count, or a start past the area end, writes nothing.
                           data_error_flag_r <= over_nxt;
                           done_r            <= 1'b1;
                        end else begin
                           wm_addr_r <= cmd_src;
                           wm_rd_r   <= 1'b1;
                           state_r   <= S_WAIT;
                        end
                     end
                     default: begin
                        // An unknown operation completes with no effect.
                        done_r <= 1'b1;
                     end
                  endcase
               end
            end

            // The read strobe is on the port during this cycle.
            S_WAIT: begin
               state_r <= S_CAP;
            end

            // Read data is valid now.
            S_CAP: begin
               case (op_r)
                  `PCP_OP_BCD_TO_BINARY: begin
                     if (bcd_err) begin
                        // A bad digit leaves the destination untouched.
                        data_error_flag_r <= 1'b1;
                        done_r            <= 1'b1;
                        state_r           <= S_IDLE;
                     end else begin
                        wm_addr_r         <= dst_r;
                        wm_wdata_r        <= bin_val;
                        wm_wr_r           <= 1'b1;
                        data_error_flag_r <= 1'b0;
                        state_r           <= S_WR;
                     end
                  end
                  `PCP_OP_BIT_DECODE: begin
                     // Only an index inside the area is written.
                     data_error_flag_r <= over_r;
                     if ({1'b0, dec_index} < cnt_r) begin
                        bm_addr_r <= dst_r + dec_index;
                        bm_set_r  <= 1'b1;
                        state_r   <= S_WR;
                     end else begin
                        done_r  <= 1'b1;
                        state_r <= S_IDLE;
                     end
                  end
                  `PCP_OP_PRIORITY_ENCODE: begin
                     // Bits are scanned upward, so the last hit is the highest.
                     if (bm_rdata) begin
                        pos_r   <= idx_r[15:0];
                        found_r <= 1'b1;
                     end
                     if (idx_last) begin
                        wm_addr_r         <= dst_r;
                        wm_wr_r           <= 1'b1;
                        data_error_flag_r <= over_r;
                        if (bm_rdata) begin
                           wm_wdata_r   <= idx_r[15:0];
                           carry_flag_r <= 1'b0;
                        end else begin
                           wm_wdata_r   <= found_r ? pos_r : 16'h0000;
                           carry_flag_r <= ~found_r;
                        end
                        state_r <= S_WR;
                     end else begin
                        idx_r     <= idx_inc;
                        bm_addr_r <= src_r + idx_inc[15:0];
                        bm_rd_r   <= 1'b1;
                        state_r   <= S_WAIT;
                     end
                  end
                  `PCP_OP_NIBBLE_PACK: begin
                     // Sources are only read; the result goes to the destination.
                     if (idx_last) begin
                        wm_addr_r         <= dst_r;
                        wm_wdata_r        <= word_r;
                        wm_wdata_r[{idx_r[1:0], 2'b00} +: 4] <= wm_rdata[3:0];
                        wm_wr_r           <= 1'b1;
                        data_error_flag_r <= over_r;
                        state_r           <= S_WR;
                     end else begin
                        word_r[{idx_r[1:0], 2'b00} +: 4] <= wm_rdata[3:0];
                        idx_r     <= idx_inc;
                        wm_addr_r <= src_r + idx_inc[15:0];
                        wm_rd_r   <= 1'b1;
                        state_r   <= S_WAIT;
                     end
                  end
                  `PCP_OP_NIBBLE_NIBBLE_DISTRIBUTE_OP: begin
                     // Hold the source word and write its lowest field first.
                     word_r            <= wm_rdata;
                     wm_addr_r         <= dst_r;
                     wm_wdata_r        <= {12'h000, wm_rdata[3:0]};
                     wm_wr_r           <= 1'b1;
                     data_error_flag_r <= over_r;
                     state_r           <= S_WR;
                  end
                  default: begin
                     done_r  <= 1'b1;
                     state_r <= S_IDLE;
                  end
               endcase
            end

            // A write strobe is on the port. Distribute keeps writing one word a
            // cycle until its clipped count is used up; fields beyond the area
            // end are simply never written.
            S_WR: begin
               if (op_r == `PCP_OP_NIBBLE_NIBBLE_DISTRIBUTE_OP && !idx_last) begin
                  idx_r      <= idx_inc;
                  wm_addr_r  <= dst_r + idx_inc[15:0];
                  wm_wdata_r <= {12'h000, word_r[{idx_inc[1:0], 2'b00} +: 4]};
                  wm_wr_r    <= 1'b1;
               end else begin
                  done_r  <= 1'b1;
                  state_r <= S_IDLE;
               end
            end

            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

   // The two flags stand on their own ports between operations, readable by
   // the program as special internal outputs; they change only with an operation's first write, or with done if it writes nothing.

endmodule

// *** tb/pcp_unit_props.sv ***
// Checker of command timing, flag ownership and write shape for the convert and pack unit.
`timescale 1ns/1ns
`include "pcp_consts.vh"

module pcp_unit_props (
   // Clock and reset.
   input wire        clock,
   input wire        rst,
   // Command port.
   input wire        cmd_valid,
   input wire        cmd_ready,
   input wire [2:0]  cmd_op,
   input wire [3:0]  cmd_n,
   input wire        done_r,
   // Memory strobes and data.
   input wire        wm_rd_r,
   input wire        wm_wr_r,
   input wire [15:0] wm_wdata_r,
   input wire        bm_set_r,
   // Flags.
   input wire        data_error_flag_r,
   input wire        carry_flag_r
);
   reg [2:0] op_r;
   reg [3:0] n_r;
   wire      take;

   assign take = cmd_valid && cmd_ready;

   // Latch the running command so that each write can be judged by its operation.
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         op_r <= 3'h7;
         n_r  <= 4'h0;
      end else if (take) begin
         op_r <= cmd_op;
         n_r  <= cmd_n;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // Accepted commands of the two kinds whose timing is fixed.
   sequence s_bin_take;
      take && cmd_op == `PCP_OP_BCD_TO_BINARY;
   endsequence
   sequence s_nibble_distribute_op_none;
      take && cmd_op == `PCP_OP_NIBBLE_NIBBLE_DISTRIBUTE_OP && cmd_n == 4'h0;
   endsequence

   // An empty distribute or an unknown operation finishes in the next cycle and
   // stays idle, so ready may only stay high when done answers at once.
   busy_after_take_a: assert property (take |=> !cmd_ready || done_r)
      else $error("ready stayed high after a command was taken");
   // A command taken in the done cycle may finish at once and pulse done again.
   done_one_cycle_a: assert property (done_r && !take |=> !done_r)
      else $error("done lasted more than one cycle");
   done_ready_a: assert property (done_r |-> cmd_ready)
      else $error("unit not ready in its done cycle");
   bin_reads_src_a: assert property (s_bin_take |=> wm_rd_r ##1 !wm_rd_r)
      else $error("conversion did not read its source once");
   bin_done_time_a: assert property (s_bin_take |-> ##[3:4] done_r)
      else $error("conversion finished at the wrong time");
   bin_ok_write_a: assert property (s_bin_take ##3 !data_error_flag_r |-> wm_wr_r)
      else $error("good conversion wrote no result");
   bin_err_nowrite_a: assert property (s_bin_take ##3 data_error_flag_r |-> done_r && !wm_wr_r)
      else $error("bad digit conversion wrote a result");
   nibble_distribute_op_zero_idle_a: assert property (s_nibble_distribute_op_none |=> done_r && !wm_wr_r)
      else $error("zero count distribute wrote or ran on");
   nibble_distribute_op_upper_clear_a: assert property ((op_r == `PCP_OP_NIBBLE_NIBBLE_DISTRIBUTE_OP && wm_wr_r) |-> wm_wdata_r[15:4] == 12'h000)
      else $error("distributed word has upper bits set");
   priority_encode_op_upper_clear_a: assert property ((op_r == `PCP_OP_PRIORITY_ENCODE && wm_wr_r) |-> (wm_wdata_r >> n_r) == 16'h0000)
      else $error("encoded position wider than its range");
   carry_owner_a: assert property ($changed(carry_flag_r) |-> op_r == `PCP_OP_PRIORITY_ENCODE)
      else $error("carry changed outside an encode");
   decode_bit_only_a: assert property (bm_set_r |-> op_r == `PCP_OP_BIT_DECODE && !wm_wr_r)
      else $error("bit set outside a decode");
endmodule

bind pcp_unit pcp_unit_props u_props (
   .clock             (clock),
   .rst               (rst),
   .cmd_valid         (cmd_valid),
   .cmd_ready         (cmd_ready),
   .cmd_op            (cmd_op),
   .cmd_n             (cmd_n),
   .done_r            (done_r),
   .wm_rd_r           (wm_rd_r),
   .wm_wr_r           (wm_wr_r),
   .wm_wdata_r        (wm_wdata_r),
   .bm_set_r          (bm_set_r),
   .data_error_flag_r (data_error_flag_r),
   .carry_flag_r      (carry_flag_r)
);

// *** tb/pcp_unit_bench.sv ***
// Self-checking bench for the convert and pack unit with a behavioural memory and result model.
`timescale 1ns/1ns
`include "pcp_consts.vh"

module pcp_unit_bench;
   reg          clock;
   reg          rst;
   reg          cmd_valid;
   reg  [2:0]   cmd_op;
   reg  [15:0]  cmd_dst;
   reg  [15:0]  cmd_src;
   reg  [3:0]   cmd_n;
   reg  [15:0]  src_last;
   reg  [15:0]  dst_last;
   reg  [15:0]  wm_rdata;
   reg          bm_rdata;
   wire         cmd_ready;
   wire         done_r;
   wire [15:0]  wm_addr_r;
   wire         wm_rd_r;
   wire         wm_wr_r;
   wire [15:0]  wm_wdata_r;
   wire [15:0]  bm_addr_r;
   wire         bm_rd_r;
   wire         bm_set_r;
   wire         data_error_flag_r;
   wire         carry_flag_r;
   reg  [15:0]  wmem [0:255];
   reg          bmem [0:255];
   reg          wq;
   reg          bq;
   reg  [15:0]  wa;
   reg  [15:0]  ba;
   int          ew [0:255];
   int          eb [0:255];
   int          eder;
   int          ecar;
   int          fails;
   int          tests_run;
   int unsigned seed;

   pcp_unit dut (.clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_op(cmd_op), .cmd_dst(cmd_dst), .cmd_src(cmd_src), .cmd_n(cmd_n),
      .src_last(src_last), .dst_last(dst_last), .done_r(done_r), .wm_addr_r(wm_addr_r),
      .wm_rd_r(wm_rd_r), .wm_rdata(wm_rdata), .wm_wr_r(wm_wr_r), .wm_wdata_r(wm_wdata_r),
      .bm_addr_r(bm_addr_r), .bm_rd_r(bm_rd_r), .bm_rdata(bm_rdata), .bm_set_r(bm_set_r),
      .data_error_flag_r(data_error_flag_r), .carry_flag_r(carry_flag_r));

   // Free-running 25 MHz clock.
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // Xorshift source, so every run repeats the same stimulus.
   function automatic int rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return int'(seed & 32'h7FFFFFFF);
   endfunction

   // Counts a comparison and reports a mismatch at once.
   task automatic chk(input bit ok, input string m);
      tests_run++;
      if (!ok) begin
         fails++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask

   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Memory side: writes land on the strobe edge; a read answers one cycle later.
   always @(posedge clock) begin
      wq <= wm_rd_r;
      wa <= wm_addr_r;
      bq <= bm_rd_r;
      ba <= bm_addr_r;
      if (wm_wr_r)
         wmem[wm_addr_r[7:0]] <= wm_wdata_r;
      if (bm_set_r)
         bmem[bm_addr_r[7:0]] <= 1'b1;
      if ((wm_wr_r && wm_addr_r > 16'h00FF) || (bm_set_r && bm_addr_r > 16'h00FF))
         chk(1'b0, "write outside the test memory");
   end

   // Outside an answer the data lines flip, so a stale read never looks right by chance.
   always @(negedge clock) begin
      wm_rdata <= wq ? wmem[wa[7:0]] : ~wm_rdata;
      bm_rdata <= bq ? bmem[ba[7:0]] : ~bm_rdata;
   end

   task automatic put(input int a, input int v);
      wmem[a] = v[15:0];
      ew[a] = v & 32'hFFFF;
   endtask

   task automatic putb(input int a, input int v);
      bmem[a] = v[0];
      eb[a] = v & 1;
   endtask

   // Reference result of one command, applied to the expected memory and flags.
   task automatic model(input int op, input int d, input int s, input int n, input int sl,
                        input int dl);
      int k;
      int b;
      int l;
      int c;
      int v;
      int e;
      v = 0;
      e = 0;
      k = (op >= 3) ? ((n > 4) ? 4 : n) : (1 << n);
      b = (op == 1 || op == 4) ? d : s;
      l = (op == 1 || op == 4) ? dl : sl;
      c = (b > l) ? 0 : ((b + k - 1 > l) ? l - b + 1 : k);
      if (op > 0 && op < 5)
         eder = (k > 0) && (b + k - 1 > l);
      case (op)
         0: begin
            for (int i = 3; i >= 0; i--) begin
               e = e | (((ew[s] >> (4 * i)) & 15) > 9);
               v = v * 10 + ((ew[s] >> (4 * i)) & 15);
            end
            eder = e;
            if (!e)
               ew[d] = v;
         end
         1: begin
            v = ew[s] & (k - 1);
            if (v < c)
               eb[d + v] = 1;
         end
         2: begin
            ecar = 1;
            for (int i = 0; i < c; i++)
               if (eb[s + i] == 1) begin
                  v = i;
                  ecar = 0;
               end
            ew[d] = v;
         end
         3: begin
            for (int i = 0; i < c; i++)
               v = v | ((ew[s + i] & 15) << (4 * i));
            ew[d] = v;
         end
         4: begin
            v = ew[s];
            for (int i = 0; i < c; i++)
               ew[d + i] = (v >> (4 * i)) & 15;
         end
         default: ;
      endcase
   endtask

   // Issue one command at a falling edge, wait for its end, then compare everything.
   task automatic run(input int op, input int d, input int s, input int n, input int sl,
                      input int dl);
      int t;
      int e;
      model(op, d, s, n, sl, dl);
      cmd_op = op[2:0];
      cmd_dst = d[15:0];
      cmd_src = s[15:0];
      cmd_n = n[3:0];
      src_last = sl[15:0];
      dst_last = dl[15:0];
      cmd_valid = 1'b1;
      @(negedge clock);
      cmd_valid = 1'b0;
      t = 0;
      while (done_r !== 1'b1) begin
         if (t == 100) begin
            chk(1'b0, "command never finished");
            close_out();
         end
         @(negedge clock);
         t++;
      end
      chk(data_error_flag_r === eder[0], "data error flag");
      chk(carry_flag_r === ecar[0], "carry flag");
      e = 0;
      for (int i = 0; i < 256; i++)
         e = e | (wmem[i] !== ew[i][15:0]) | (bmem[i] !== eb[i][0]);
      chk(!e, "memory contents");
      // Let one edge pass so that the next request never lowers and raises valid at once.
      @(negedge clock);
   endtask

   // Main sequence: reset, directed cases per operation, then a random mix.
   initial begin
      int v;
      rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_op = 3'h0;
      cmd_dst = 16'h0000;
      cmd_src = 16'h0000;
      cmd_n = 4'h0;
      src_last = 16'h0000;
      dst_last = 16'h0000;
      wm_rdata = 16'h0000;
      bm_rdata = 1'b0;
      seed = 98;
      fails = 0;
      tests_run = 0;
      eder = 0;
      ecar = 0;
      for (int i = 0; i < 256; i++) begin
         put(i, rnd());
         putb(i, 0);
      end
      repeat (12) @(negedge clock);
      rst = 1'b0;
      @(negedge clock);
      chk(cmd_ready === 1'b1 && done_r === 1'b0, "idle after reset");
      put(10, 16'h1000);
      put(11, 16'h12A4);
      put(12, 16'h9999);
      run(0, 20, 10, 0, 255, 255);
      run(0, 21, 11, 0, 255, 255);
      run(0, 22, 12, 0, 255, 255);
      for (int i = 0; i < 8; i++) begin
         v = 0;
         for (int j = 0; j < 4; j++)
            v = (v << 4) | (rnd() % ((i % 2) ? 16 : 10));
         put(14, v);
         run(0, 24, 14, 0, 255, 255);
      end
      $display("bcd conversion test done");
      put(30, 16'h0008);
      put(31, 16'h000D);
      put(32, 16'hFFF3);
      run(1, 100, 30, 4, 255, 255);
      run(1, 100, 32, 2, 255, 255);
      run(1, 130, 30, 0, 255, 255);
      run(1, 112, 30, 4, 255, 125);
      run(1, 112, 31, 4, 255, 123);
      $display("decode test done");
      putb(140, 1);
      putb(142, 1);
      putb(145, 1);
      run(2, 40, 140, 3, 255, 255);
      run(2, 41, 150, 3, 255, 255);
      run(2, 42, 140, 3, 143, 255);
      run(2, 43, 144, 2, 255, 255);
      run(2, 44, 200, 2, 150, 255);
      $display("encode test done");
      for (int i = 0; i < 4; i++)
         put(50 + i, (rnd() & 32'hFFF0) | (i + 1));
      run(3, 60, 50, 3, 255, 255);
      run(3, 61, 50, 4, 52, 255);
      run(3, 62, 50, 7, 255, 255);
      run(3, 63, 50, 0, 255, 255);
      $display("pack test done");
      put(70, 16'h1234);
      for (int n = 4; n > 0; n--) begin
         for (int i = 80; i < 84; i++)
            put(i, rnd());
         run(4, 80, 70, n, 255, 82);
      end
      run(4, 90, 70, 0, 255, 255);
      run(4, 95, 70, 2, 255, 90);
      for (int op = 5; op < 8; op++)
         run(op, 20, 10, 1, 255, 255);
      $display("distribute test done");
      for (int i = 0; i < 24; i++)
         run(rnd() % 5, rnd() % 192, rnd() % 192, rnd() % 5, 200 + rnd() % 56, 200 + rnd() % 56);
      $display("random mix test done");
      close_out();
   end
endmodule
